// [inc/cmas_pkg.sv]
package cmas_pkg;

	// ==========================================================
	// Register map (index = byte address on the plain port)
	localparam logic [3:0] ADDR_CORE_MODE_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_EXC_SP           = 4'h1;
	localparam logic [3:0] ADDR_UNPRIV_SP        = 4'h2;
	localparam logic [3:0] ADDR_SUPER_SP         = 4'h3;
	localparam logic [3:0] ADDR_VECTOR_BASE      = 4'h4;
	localparam logic [3:0] ADDR_STATUS           = 4'h5;

	// ==========================================================
	// Core mode configuration fields
	localparam int             CFG_WIDE_DISPATCH_BIT = 8;
	localparam int             CFG_SHORT_REG_BIT     = 9;
	localparam logic [15:0]    CFG_RESET             = 16'h0000;
	localparam logic [15:0]    CFG_WRITE_MASK        = 16'h0300;

	// ==========================================================
	// Address limits and masks
	localparam logic [31:0] UNPRIV_SP_LIMIT = 32'h00ff_ffff;
	localparam logic [31:0] EXC_SP_MASK     = 32'h00ff_fffe;
	localparam logic [31:0] LOW16_MASK      = 32'h0000_ffff;
	localparam logic [31:0] ABS20_MASK      = 32'h000f_ffff;
	localparam logic [31:0] ABS24_MASK      = 32'h00ff_ffff;
	localparam logic [31:0] DISP14_MASK     = 32'h0000_3fff;
	localparam logic [31:0] DISP20_MASK     = 32'h000f_ffff;
	localparam logic [31:0] ZERO32          = 32'h0000_0000;
	localparam logic [31:0] PUSH_STEP       = 32'h0000_0002;
	localparam int          NARROW_ENTRY_SHIFT = 1;
	localparam int          WIDE_ENTRY_SHIFT   = 2;

	// ==========================================================
	// Address generation modes
	typedef enum logic [2:0] {
		CMAS_AM_NONE,
		CMAS_AM_RELATIVE,
		CMAS_AM_RELATIVE_PAIR,
		CMAS_AM_INDEX_REL,
		CMAS_AM_INDEX_ABS,
		CMAS_AM_ABSOLUTE,
		CMAS_AM_BRANCH
	} cmas_amode_t;

	// Stack operations
	typedef enum logic [2:0] {
		CMAS_SO_NONE,
		CMAS_SO_PUSH,
		CMAS_SO_POP,
		CMAS_SO_POP_AND_RETURN,
		CMAS_SO_EXC_ENTRY,
		CMAS_SO_EXC_RETURN
	} cmas_sop_t;

endpackage : cmas_pkg

// [hw/cmas_core.sv]
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
module cmas_core (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// Register port
	input  wire logic [3:0]               reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// Address generation request
	input  wire logic                     ag_valid,
	input  wire cmas_pkg::cmas_amode_t    ag_mode,
	input  wire logic                     ag_base_sel_b,
	input  wire logic [15:0]              ag_base_lo,
	input  wire logic [15:0]              ag_base_hi,
	input  wire logic [15:0]              ag_base_a,
	input  wire logic [15:0]              ag_base_a_hi,
	input  wire logic [15:0]              ag_base_b,
	input  wire logic [15:0]              ag_base_b_hi,
	input  wire logic [31:0]              ag_disp,
	input  wire logic                     ag_disp_long,
	input  wire logic                     ag_abs_long,
	input  wire logic [23:0]              ag_pc,
	// Address generation answer
	output logic      [31:0]              ag_addr,
	output logic                          ag_done,
	output logic                          ag_illegal,
	// Stack request
	input  wire logic                     st_valid,
	input  wire cmas_pkg::cmas_sop_t      st_op,
	input  wire logic [31:0]              st_size,
	input  wire logic [31:0]              st_jump_target,
	// Stack answer
	output logic      [31:0]              st_addr,
	output logic                          st_done,
	output logic                          st_trap,
	// Exception dispatch lookup
	input  wire logic                     vec_valid,
	input  wire logic [7:0]               vec_number,
	output logic      [31:0]              vec_entry_addr,
	output logic                          vec_entry_wide,
	// Mode and privilege
	input  wire logic                     jump_to_unprivileged,
	input  wire logic                     load_proc_reg_double,
	output logic                          unprivileged_mode_flag,
	output logic                          load_proc_reg_double_blocked,
	output logic                          short_reg_compat,
	output logic                          wide_dispatch_select,
	// Register write merge
	input  wire logic                     wb_valid,
	input  wire logic                     wb_byte,
	input  wire logic [15:0]              wb_old,
	input  wire logic [15:0]              wb_new,
	output logic      [15:0]              wb_result
);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] pair_join(input logic [15:0] lo,
		input logic [15:0] hi);
		pair_join = {hi, lo};
	endfunction : pair_join

	function automatic logic [31:0] base_value(input logic shrt,
		input logic [15:0] lo, input logic [15:0] hi);
		base_value = shrt ? {16'h0000, lo} : {hi, lo};
	endfunction : base_value

	// ==========================================================
	// State
	logic [15:0] core_mode_config;
	logic [31:0] exc_sp;
	logic [31:0] unpriv_sp;
	logic [31:0] super_sp;
	logic [31:0] vector_base;
	logic        unpriv;
	logic        saved_unpriv;

	logic [15:0] next_core_mode_config;
	logic [31:0] next_exc_sp;
	logic [31:0] next_unpriv_sp;
	logic [31:0] next_super_sp;
	logic [31:0] next_vector_base;
	logic        next_unpriv;
	logic        next_saved_unpriv;
	logic [31:0] next_reg_rdata;
	logic [31:0] next_ag_addr;
	logic        next_ag_done;
	logic        next_ag_illegal;
	logic [31:0] next_st_addr;
	logic        next_st_done;
	logic        next_st_trap;
	logic [31:0] next_vec_entry_addr;
	logic [15:0] next_wb_result;
	logic        next_load_proc_reg_double_blocked;
	logic [31:0] next_exc_sp_stack;

	logic        shrt;
	logic        wide;
	logic [31:0] prog_sp;
	logic [31:0] idx_base;

	assign shrt = core_mode_config[cmas_pkg::CFG_SHORT_REG_BIT];
	assign wide = core_mode_config[cmas_pkg::CFG_WIDE_DISPATCH_BIT];
	assign prog_sp = unpriv ? unpriv_sp : super_sp;
	assign idx_base = ag_base_sel_b ?
		base_value(shrt, ag_base_b, ag_base_b_hi) :
		base_value(shrt, ag_base_a, ag_base_a_hi);

	// ==========================================================
	// Register port and configuration
	always_comb begin
		next_core_mode_config = core_mode_config;
		next_exc_sp           = exc_sp;
		next_vector_base      = vector_base;
		next_reg_rdata        = cmas_pkg::ZERO32;
		if (reg_wr) begin
			unique case (reg_addr)
				cmas_pkg::ADDR_CORE_MODE_CONFIG:
					// Cache bits are dropped: no cache here
					next_core_mode_config = reg_wdata[15:0] &
						cmas_pkg::CFG_WRITE_MASK;
				cmas_pkg::ADDR_EXC_SP:
					next_exc_sp = reg_wdata & cmas_pkg::EXC_SP_MASK;
				cmas_pkg::ADDR_VECTOR_BASE:
					next_vector_base = reg_wdata & cmas_pkg::EXC_SP_MASK;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				cmas_pkg::ADDR_CORE_MODE_CONFIG:
					next_reg_rdata = {16'h0000, core_mode_config};
				cmas_pkg::ADDR_EXC_SP:
					next_reg_rdata = exc_sp & cmas_pkg::EXC_SP_MASK;
				cmas_pkg::ADDR_UNPRIV_SP:   next_reg_rdata = unpriv_sp;
				cmas_pkg::ADDR_SUPER_SP:    next_reg_rdata = super_sp;
				cmas_pkg::ADDR_VECTOR_BASE: next_reg_rdata = vector_base;
				cmas_pkg::ADDR_STATUS:
					next_reg_rdata = {31'h0000_0000, unpriv};
				default: next_reg_rdata = cmas_pkg::ZERO32;
			endcase
		end
	end

	// ==========================================================
	// Address generation
	always_comb begin
		next_ag_addr    = ag_addr;
		next_ag_done    = 1'b0;
		next_ag_illegal = 1'b0;
		if (ag_valid) begin
			next_ag_done = 1'b1;
			// Base operands are only read here, never written back
			unique case (ag_mode)
				cmas_pkg::CMAS_AM_BRANCH:
					next_ag_addr = {8'h00, ag_pc} + ag_disp;
				cmas_pkg::CMAS_AM_RELATIVE:
					next_ag_addr = {16'h0000, ag_base_lo} + ag_disp;
				cmas_pkg::CMAS_AM_RELATIVE_PAIR: begin
					if (shrt)
						// Short mode: 0/14-bit offsets replace index
						next_ag_addr = pair_join(ag_base_lo, ag_base_hi) +
							(ag_disp & cmas_pkg::DISP14_MASK);
					else
						next_ag_addr = pair_join(ag_base_lo, ag_base_hi) +
							ag_disp;
				end
				cmas_pkg::CMAS_AM_INDEX_REL: begin
					if (shrt)
						next_ag_illegal = 1'b1;
					else
						next_ag_addr = idx_base +
							pair_join(ag_base_lo, ag_base_hi) +
							(ag_disp & (ag_disp_long ?
							cmas_pkg::DISP20_MASK :
							cmas_pkg::DISP14_MASK));
				end
				cmas_pkg::CMAS_AM_INDEX_ABS: begin
					if (shrt)
						next_ag_illegal = 1'b1;
					else
						next_ag_addr = idx_base +
							(ag_disp & cmas_pkg::ABS20_MASK);
				end
				cmas_pkg::CMAS_AM_ABSOLUTE:
					next_ag_addr = ag_disp & (ag_abs_long ?
						cmas_pkg::ABS24_MASK :
						cmas_pkg::ABS20_MASK);
				default: next_ag_done = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Stacks and privilege
	always_comb begin
		next_unpriv_sp    = unpriv_sp;
		next_super_sp     = super_sp;
		next_unpriv       = unpriv;
		next_saved_unpriv = saved_unpriv;
		next_st_addr      = st_addr;
		next_st_done      = 1'b0;
		next_st_trap      = 1'b0;
		next_load_proc_reg_double_blocked = load_proc_reg_double & unpriv;
		if (reg_wr && reg_addr == cmas_pkg::ADDR_UNPRIV_SP)
			next_unpriv_sp = reg_wdata;
		if (reg_wr && reg_addr == cmas_pkg::ADDR_SUPER_SP)
			next_super_sp = reg_wdata;
		if (st_valid) begin
			next_st_done = 1'b1;
			unique case (st_op)
				cmas_pkg::CMAS_SO_PUSH: begin
					if (unpriv && unpriv_sp > cmas_pkg::UNPRIV_SP_LIMIT)
						next_st_trap = 1'b1;
					else begin
						next_st_addr = prog_sp - st_size;
						if (unpriv) next_unpriv_sp = next_st_addr;
						else        next_super_sp  = next_st_addr;
					end
				end
				cmas_pkg::CMAS_SO_POP,
				cmas_pkg::CMAS_SO_POP_AND_RETURN: begin
					if (unpriv && unpriv_sp > cmas_pkg::UNPRIV_SP_LIMIT)
						next_st_trap = 1'b1;
					else begin
						next_st_addr = prog_sp;
						if (unpriv) next_unpriv_sp = prog_sp + st_size;
						else        next_super_sp  = prog_sp + st_size;
					end
				end
				cmas_pkg::CMAS_SO_EXC_ENTRY: begin
					next_st_addr      = (exc_sp - st_size) &
						cmas_pkg::EXC_SP_MASK;
					next_saved_unpriv = unpriv;
					next_unpriv       = 1'b0;
				end
				cmas_pkg::CMAS_SO_EXC_RETURN: begin
					next_st_addr = exc_sp;
					next_unpriv  = saved_unpriv;
				end
				default: next_st_done = 1'b0;
			endcase
		end
		if (jump_to_unprivileged && !(st_valid &&
			st_op == cmas_pkg::CMAS_SO_EXC_ENTRY))
			next_unpriv = 1'b1;
	end

	// Exception pointer follows entry/return so nested entries stack
	always_comb begin
		next_exc_sp_stack = next_exc_sp;
		if (st_valid && st_op == cmas_pkg::CMAS_SO_EXC_ENTRY)
			next_exc_sp_stack = (exc_sp - st_size) &
				cmas_pkg::EXC_SP_MASK;
		else if (st_valid && st_op == cmas_pkg::CMAS_SO_EXC_RETURN)
			next_exc_sp_stack = (exc_sp + st_size) &
				cmas_pkg::EXC_SP_MASK;
	end

	// ==========================================================
	// Dispatch lookup and byte merge
	always_comb begin
		next_vec_entry_addr = vec_entry_addr;
		if (vec_valid)
			next_vec_entry_addr = vector_base + (wide ?
				({24'h000000, vec_number} << cmas_pkg::WIDE_ENTRY_SHIFT) :
				({24'h000000, vec_number} << cmas_pkg::NARROW_ENTRY_SHIFT));
		next_wb_result = wb_result;
		if (wb_valid)
			next_wb_result = wb_byte ? {wb_old[15:8], wb_new[7:0]}
				: wb_new;
	end

	// ==========================================================
	// Registers: configuration, exception pointer, read port
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			core_mode_config       <= cmas_pkg::CFG_RESET;
			exc_sp                 <= cmas_pkg::ZERO32;
			vector_base            <= cmas_pkg::ZERO32;
			reg_rdata              <= cmas_pkg::ZERO32;
			short_reg_compat       <= 1'b0;
			wide_dispatch_select   <= 1'b0;
		end else begin
			core_mode_config       <= next_core_mode_config;
			exc_sp                 <= next_exc_sp_stack;
			vector_base            <= next_vector_base;
			reg_rdata              <= next_reg_rdata;
			// Mode outputs follow the new value so they track writes
			short_reg_compat       <= next_core_mode_config[
				cmas_pkg::CFG_SHORT_REG_BIT];
			wide_dispatch_select   <= next_core_mode_config[
				cmas_pkg::CFG_WIDE_DISPATCH_BIT];
		end
	end

	// ==========================================================
	// Registers: address generation
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ag_addr                <= cmas_pkg::ZERO32;
			ag_done                <= 1'b0;
			ag_illegal             <= 1'b0;
		end else begin
			ag_addr                <= next_ag_addr;
			ag_done                <= next_ag_done;
			ag_illegal             <= next_ag_illegal;
		end
	end

	// ==========================================================
	// Registers: program stacks and privilege
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unpriv_sp              <= cmas_pkg::ZERO32;
			super_sp               <= cmas_pkg::ZERO32;
			unpriv                 <= 1'b0;
			saved_unpriv           <= 1'b0;
			st_addr                <= cmas_pkg::ZERO32;
			st_done                <= 1'b0;
			st_trap                <= 1'b0;
			unprivileged_mode_flag <= 1'b0;
			load_proc_reg_double_blocked           <= 1'b0;
		end else begin
			unpriv_sp              <= next_unpriv_sp;
			super_sp               <= next_super_sp;
			unpriv                 <= next_unpriv;
			saved_unpriv           <= next_saved_unpriv;
			st_addr                <= next_st_addr;
			st_done                <= next_st_done;
			st_trap                <= next_st_trap;
			unprivileged_mode_flag <= next_unpriv;
			load_proc_reg_double_blocked           <= next_load_proc_reg_double_blocked;
		end
	end

	// ==========================================================
	// Registers: dispatch lookup and byte merge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vec_entry_addr         <= cmas_pkg::ZERO32;
			vec_entry_wide         <= 1'b0;
			wb_result              <= 16'h0000;
		end else begin
			vec_entry_addr         <= next_vec_entry_addr;
			vec_entry_wide         <= next_core_mode_config[
				cmas_pkg::CFG_WIDE_DISPATCH_BIT];
			wb_result              <= next_wb_result;
		end
	end

endmodule : cmas_core

// [verification/cmas_pipe_model.sv]
`timescale 1ns/100ps
// ==========================================
// Pipeline side: issues program and exception stack requests
module cmas_pipe_model (
	// Clock
	input  wire logic                sys_clk,
	// Command from the bench
	input  wire logic                go,
	input  wire cmas_pkg::cmas_sop_t op,
	input  wire logic [31:0]         sz,
	// Stack request to the core
	output cmas_pkg::cmas_sop_t      st_op,
	output logic                     st_valid,
	output logic [31:0]              st_size
);
	// Any op from the bench reaches the stack while go is high; CMAS_SO_NONE is sent while idle
	always_ff @(posedge sys_clk) begin
		st_valid <= go;
		st_op    <= go ? op : cmas_pkg::CMAS_SO_NONE;
		// Idle size shows the inverse so a stale value is never trusted
		st_size  <= go ? sz : ~sz;
	end
endmodule : cmas_pipe_model

// [verification/cmas_core_chk.sv]
`timescale 1ns/100ps
// ==========================================
// Checker
module cmas_core_chk (
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  rst,
	// Address generation
	input wire logic                  ag_valid,
	input wire cmas_pkg::cmas_amode_t ag_mode,
	input wire logic [31:0]           ag_disp,
	input wire logic                  ag_abs_long,
	input wire logic [23:0]           ag_pc,
	input wire logic [31:0]           ag_addr,
	input wire logic                  ag_done,
	input wire logic                  ag_illegal,
	// Stack and mode
	input wire logic                  st_valid,
	input wire cmas_pkg::cmas_sop_t   st_op,
	input wire logic [31:0]           st_addr,
	input wire logic                  st_done,
	input wire logic                  jump_to_unprivileged,
	input wire logic                  load_proc_reg_double,
	input wire logic                  unprivileged_mode_flag,
	input wire logic                  load_proc_reg_double_blocked,
	input wire logic                  short_reg_compat,
	input wire logic                  wide_dispatch_select,
	// Write merge
	input wire logic                  wb_valid,
	input wire logic                  wb_byte,
	input wire logic [15:0]           wb_old,
	input wire logic [15:0]           wb_new,
	input wire logic [15:0]           wb_result
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_CFG_RST: assert property ($fell(rst) |-> !short_reg_compat && !wide_dispatch_select) else $error("config not clear");
	AST_BRANCH: assert property (ag_valid && ag_mode == cmas_pkg::CMAS_AM_BRANCH |=> ag_done && ag_addr == {8'h00, $past(ag_pc)} + $past(ag_disp)) else $error("branch target");
	AST_ABS24: assert property (ag_valid && ag_abs_long && ag_mode == cmas_pkg::CMAS_AM_ABSOLUTE |=> ag_addr == ($past(ag_disp) & 32'h00ff_ffff)) else $error("absolute addr");
	AST_IDX_SHORT: assert property (ag_valid && short_reg_compat && (ag_mode == cmas_pkg::CMAS_AM_INDEX_REL || ag_mode == cmas_pkg::CMAS_AM_INDEX_ABS) |=> ag_illegal && $stable(ag_addr)) else $error("index in short mode");
	AST_EXC_ESP: assert property (st_valid && st_op == cmas_pkg::CMAS_SO_EXC_ENTRY |=> st_done && st_addr[31:24] == 8'h00 && !st_addr[0]) else $error("exception sp bits");
	AST_EXC_LEAVE: assert property (st_valid && st_op == cmas_pkg::CMAS_SO_EXC_ENTRY |=> !unprivileged_mode_flag) else $error("mode not left");
	AST_USER_ENTRY: assert property ($rose(unprivileged_mode_flag) |-> $past(jump_to_unprivileged) || ($past(st_valid) && $past(st_op) == cmas_pkg::CMAS_SO_EXC_RETURN)) else $error("bad mode entry");
	AST_LOAD_PROC_REG_DOUBLE: assert property (unprivileged_mode_flag && load_proc_reg_double |=> load_proc_reg_double_blocked) else $error("double load not blocked");
	AST_WB_BYTE: assert property (wb_valid && wb_byte |=> wb_result == (($past(wb_old) & 16'hff00) | ($past(wb_new) & 16'h00ff))) else $error("byte merge");
endmodule : cmas_core_chk

bind cmas_core cmas_core_chk u_chk (.*);

// [verification/tb.sv]
`timescale 1ns/100ps
// ==========================================
// Bench
module tb;
	logic sys_clk, rst, reg_wr, reg_rd, ag_valid, ag_base_sel_b, ag_disp_long;
	logic ag_abs_long, vec_valid, jump_to_unprivileged, load_proc_reg_double;
	logic wb_valid, wb_byte, ag_done, ag_illegal, st_valid, st_done, st_trap;
	logic vec_entry_wide, unprivileged_mode_flag, load_proc_reg_double_blocked, go;
	logic short_reg_compat, wide_dispatch_select;
	logic [3:0]  reg_addr;
	logic [7:0]  vec_number;
	logic [23:0] ag_pc;
	logic [15:0] ag_base_lo, ag_base_hi, ag_base_a, ag_base_a_hi, ag_base_b;
	logic [15:0] ag_base_b_hi, wb_old, wb_new, wb_result;
	logic [31:0] reg_wdata, reg_rdata, ag_disp, st_size, st_jump_target, sz;
	logic [31:0] st_addr, ag_addr, vec_entry_addr, e, b;
	cmas_pkg::cmas_amode_t ag_mode, m;
	cmas_pkg::cmas_sop_t   st_op, op;
	int n_errors, n_checks;

	cmas_core dut (.*);
	cmas_pipe_model pm (.*);

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		n_checks++;
		if (seen !== x) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", nm, x, seen);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge sys_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, x);
	endtask : rd
	task agt(input cmas_pkg::cmas_amode_t md, input logic [31:0] x, input logic il);
		@(posedge sys_clk) begin ag_valid <= 1'b1; ag_mode <= md; end
		@(posedge sys_clk) ag_valid <= 1'b0;
		#1 chk("ag_illegal", {31'h0, ag_illegal}, {31'h0, il});
		chk("ag_addr", ag_addr, x);
		chk("ag_done", {31'h0, ag_done}, 32'h1);
	endtask : agt
	task stk(input cmas_pkg::cmas_sop_t o, input logic [31:0] s, x, input logic t);
		@(posedge sys_clk) begin go <= 1'b1; op <= o; sz <= s; end
		@(posedge sys_clk) go <= 1'b0;
		@(posedge sys_clk) #1 chk("st_trap", {31'h0, st_trap}, {31'h0, t});
		if (!t) chk("st_addr", st_addr, x);
		chk("st_done", {31'h0, st_done}, 32'h1);
	endtask : stk
	function automatic logic [31:0] agx(input cmas_pkg::cmas_amode_t md);
		logic [31:0] pr, ib, dm;
		pr = {ag_base_hi, ag_base_lo};
		ib = ag_base_sel_b ? {ag_base_b_hi, ag_base_b} : {ag_base_a_hi, ag_base_a};
		dm = ag_disp & (ag_disp_long ? 32'h000f_ffff : 32'h0000_3fff);
		case (md)
			cmas_pkg::CMAS_AM_RELATIVE:      agx = {16'h0, ag_base_lo} + ag_disp;
			cmas_pkg::CMAS_AM_RELATIVE_PAIR: agx = pr + ag_disp;
			cmas_pkg::CMAS_AM_INDEX_REL:     agx = ib + pr + dm;
			cmas_pkg::CMAS_AM_INDEX_ABS:     agx = ib + (ag_disp & 32'h000f_ffff);
			cmas_pkg::CMAS_AM_ABSOLUTE:
				agx = ag_disp & (ag_abs_long ? 32'h00ff_ffff : 32'h000f_ffff);
			default:                         agx = {8'h00, ag_pc} + ag_disp;
		endcase
	endfunction : agx
	task final_report;
		if (n_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : final_report

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Whole run is about 250 cycles; 20000-cycle limit is a generous margin
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		final_report();
	end
	initial begin
		rst = 1'b1; go = 1'b0; sz = '0; op = cmas_pkg::CMAS_SO_NONE;
		{reg_wr, reg_rd, ag_valid, ag_base_sel_b, ag_disp_long, ag_abs_long} = '0;
		{vec_valid, jump_to_unprivileged, load_proc_reg_double} = '0;
		{wb_valid, wb_byte, wb_old, wb_new, vec_number, ag_pc, ag_disp} = '0;
		{reg_addr, reg_wdata, st_jump_target, ag_base_lo, ag_base_hi} = '0;
		{ag_base_a, ag_base_a_hi, ag_base_b, ag_base_b_hi} = '0;
		ag_mode = cmas_pkg::CMAS_AM_NONE;
		n_errors = 0; n_checks = 0;
		void'($urandom(74070));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h0);
		wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'hffff_ffff);
		rd(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h0000_0300);
		for (int w = 0; w < 2; w++) begin
			wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, w << 8);
			b = $urandom & (w ? 32'h00ff_fffe : 32'h0001_fffe);
			wr(cmas_pkg::ADDR_VECTOR_BASE, b);
			@(posedge sys_clk) begin vec_valid <= 1'b1; vec_number <= 8'($urandom); end
			@(posedge sys_clk) vec_valid <= 1'b0;
			#1 chk("vec_addr", vec_entry_addr, b + (vec_number << (w + 1)));
			chk("vec_wide", {31'h0, vec_entry_wide}, 32'(w));
			chk("wide", {31'h0, wide_dispatch_select}, 32'(w));
		end
		wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h0);
		repeat (40) begin
			m = cmas_pkg::cmas_amode_t'(3'd1 + 3'($urandom % 6));
			@(posedge sys_clk) begin
				{ag_base_lo, ag_base_hi, ag_base_a, ag_base_a_hi} <= {$urandom, $urandom};
				{ag_base_b, ag_base_b_hi, ag_pc} <= {$urandom, $urandom};
				{ag_base_sel_b, ag_disp_long, ag_abs_long} <= 3'($urandom);
				ag_disp <= (m == cmas_pkg::CMAS_AM_RELATIVE_PAIR ||
					m == cmas_pkg::CMAS_AM_BRANCH) ? $urandom & 32'h3fff : $urandom;
			end
			#1 e = agx(m);
			agt(m, e, 1'b0);
		end
		wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h200);
		#1 chk("short", {31'h0, short_reg_compat}, 32'h1);
		agt(cmas_pkg::CMAS_AM_INDEX_REL, e, 1'b1);
		agt(cmas_pkg::CMAS_AM_INDEX_ABS, e, 1'b1);
		@(posedge sys_clk) ag_disp <= $urandom | 32'h0001_0000;
		#1 e = {ag_base_hi, ag_base_lo} + (ag_disp & 32'h0000_3fff);
		agt(cmas_pkg::CMAS_AM_RELATIVE_PAIR, e, 1'b0);
		wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h0);
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk) {wb_valid, wb_byte, wb_old, wb_new} <=
				{1'b1, i[0], 32'($urandom)};
			@(posedge sys_clk) wb_valid <= 1'b0;
			#1 chk("wb", {16'h0, wb_result}, wb_byte ? {16'h0, wb_old[15:8], wb_new[7:0]} : {16'h0, wb_new});
		end
		wr(cmas_pkg::ADDR_SUPER_SP, 32'h1000);
		stk(cmas_pkg::CMAS_SO_PUSH, 32'h4, 32'h0ffc, 1'b0);
		stk(cmas_pkg::CMAS_SO_POP, 32'h2, 32'h0ffc, 1'b0);
		stk(cmas_pkg::CMAS_SO_POP_AND_RETURN, 32'h2, 32'h0ffe, 1'b0);
		rd(cmas_pkg::ADDR_SUPER_SP, 32'h1000);
		wr(cmas_pkg::ADDR_EXC_SP, 32'hff00_1001);
		rd(cmas_pkg::ADDR_EXC_SP, 32'h0000_1000);
		wr(cmas_pkg::ADDR_UNPRIV_SP, 32'h2000);
		@(posedge sys_clk) jump_to_unprivileged <= 1'b1;
		@(posedge sys_clk) jump_to_unprivileged <= 1'b0;
		#1 chk("flag", {31'h0, unprivileged_mode_flag}, 32'h1);
		stk(cmas_pkg::CMAS_SO_PUSH, 32'h2, 32'h1ffe, 1'b0);
		@(posedge sys_clk) load_proc_reg_double <= 1'b1;
		@(posedge sys_clk) load_proc_reg_double <= 1'b0;
		#1 chk("load_proc_reg_double", {31'h0, load_proc_reg_double_blocked}, 32'h1);
		stk(cmas_pkg::CMAS_SO_EXC_ENTRY, 32'h8, 32'h0ff8, 1'b0);
		chk("flag", {31'h0, unprivileged_mode_flag}, 32'h0);
		@(posedge sys_clk) load_proc_reg_double <= 1'b1;
		@(posedge sys_clk) load_proc_reg_double <= 1'b0;
		#1 chk("load_proc_reg_double", {31'h0, load_proc_reg_double_blocked}, 32'h0);
		stk(cmas_pkg::CMAS_SO_PUSH, 32'h4, 32'h0ffc, 1'b0);
		stk(cmas_pkg::CMAS_SO_EXC_RETURN, 32'h8, 32'h0ff8, 1'b0);
		chk("flag", {31'h0, unprivileged_mode_flag}, 32'h1);
		rd(cmas_pkg::ADDR_EXC_SP, 32'h1000);
		wr(cmas_pkg::ADDR_UNPRIV_SP, 32'h0100_0000);
		stk(cmas_pkg::CMAS_SO_PUSH, 32'h2, 32'h0, 1'b1);
		rd(cmas_pkg::ADDR_UNPRIV_SP, 32'h0100_0000);
		wr(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h300);
		// Reset again in mid-run
		@(posedge sys_clk) rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(cmas_pkg::ADDR_CORE_MODE_CONFIG, 32'h0);
		final_report();
	end
endmodule : tb
